// file: rtl/ebpc_pkg.sv
/*
 * package for the expanded bus and pin control block: register indices,
 * reset values, mode encodings and timing counts.
 * assumes a 250 MHz pclk and an oscillator pin far slower than pclk.
 */
// Notes on behaviour
// - oscillator input runs at four times bus clock; bus clock is oscillator divided by four
// - address bus driven while bus clock low, data bus used while bus clock high
// - data strobe is always the inverse of the bus clock
// - bus-stretch input sampled only at each bus clock rising edge
// - sampled stretch high holds bus clock high four oscillator cycles instead of two
// - sampled stretch low lets bus clock fall two oscillator cycles after rising
// - reset input starts device; reset pin pulled low open-drain on clock or watchdog fault
// - two mode pins latched at reset choose operating mode; outside holds them valid
// - after reset first mode pin is open-drain active-low instruction-start pulse
// - in expanded and test modes read/write line shows data bus direction
// - port A: 8-bit bidirectional, data and direction registers, timer shared, inputs after reset
// - port B output-only: general outputs single-chip, upper address byte expanded
// - port C bidirectional with registers: general I/O single-chip, data bus expanded
// - port D: six bidirectional lines with registers, general I/O or serial unit signals
// - port E 8-bit input-only, shared with converter; unused pins read as inputs
// - active-low interrupt-request input raises a maskable interrupt request
package ebpc_pkg;
	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_PORT_A_DATA  = 8'h00;
	localparam logic [7:0] IDX_PORT_A_DIR   = 8'h01;
	localparam logic [7:0] IDX_PORT_B_DATA  = 8'h04;
	localparam logic [7:0] IDX_PORT_C_DATA  = 8'h06;
	localparam logic [7:0] IDX_PORT_C_DIR   = 8'h07;
	localparam logic [7:0] IDX_PORT_D_DATA  = 8'h08;
	localparam logic [7:0] IDX_PORT_D_DIR   = 8'h09;
	localparam logic [7:0] IDX_PORT_E_INPUT = 8'h0A;
	localparam logic [7:0] IDX_SYS_CTRL     = 8'h5E;
	localparam logic [7:0] IDX_SYS_STATUS   = 8'h5F;
	localparam int         IDX_LSB          = 2;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_PORT_DATA    = 8'h00;
	localparam logic [7:0] RST_PORT_DIR     = 8'h00;
	localparam logic [5:0] RST_PORT_D6      = 6'h00;
	localparam logic [1:0] RST_MODE         = 2'h0;
	localparam logic       RST_IRQ_EN       = 1'b0;
	// ==========================================================
	// field positions
	localparam int         CTRL_IRQ_EN_BIT  = 0;
	localparam int         STAT_MODE_LSB    = 0;
	localparam int         STAT_MODE_OK_BIT = 2;
	localparam int         STAT_IRQ_BIT     = 3;
	localparam int         STAT_FAULT_BIT   = 4;
	// ==========================================================
	// modes as {mode_sel_b, mode_sel_a}
	typedef enum logic [1:0] {
		EBPC_MODE_BOOT   = 2'b00,
		EBPC_MODE_TEST   = 2'b01,
		EBPC_MODE_SINGLE = 2'b10,
		EBPC_MODE_EXPAND = 2'b11
	} ebpc_mode_t;
	// ==========================================================
	// bus clock timing in oscillator rising edges; mode capture count in pclk cycles
	localparam logic [2:0] OSC_LOW_CNT      = 3'd2;
	localparam logic [2:0] OSC_HIGH_CNT     = 3'd2;
	localparam logic [2:0] OSC_STRETCH_CNT  = 3'd4;
	localparam logic [1:0] MODE_CAPTURE_CNT = 2'd2;
endpackage : ebpc_pkg

// file: rtl/ebpc_eclk_gen.sv
/*
 * bus clock generator: divides the oscillator edges by four and
 * stretches the high phase when the stretch input is sampled high.
 * assumes osc_rise is a one-cycle pulse per oscillator rising edge and
 * stretch_lvl is already synchronised to pclk.
 */
`timescale 1ns/10ps
module ebpc_eclk_gen
	import ebpc_pkg::*;
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// oscillator edge and stretch level
	input  wire logic osc_rise,
	input  wire logic stretch_lvl,
	// bus clock
	output logic      bus_clk,
	output logic      bus_rise,
	output logic      bus_fall
);
	import ebpc_pkg::*;

	typedef enum logic [0:0] {
		EBPC_E_LOW  = 1'b0,
		EBPC_E_HIGH = 1'b1
	} ebpc_e_state_t;

	ebpc_e_state_t state;
	ebpc_e_state_t next_state;
	logic [2:0]    count;
	logic [2:0]    next_count;
	logic [2:0]    limit;
	logic [2:0]    next_limit;
	logic          next_rise;
	logic          next_fall;

	// ==========================================================
	// next state
	always_comb begin
		next_state = state;
		next_count = count;
		next_limit = limit;
		next_rise  = 1'b0;
		next_fall  = 1'b0;
		if (osc_rise) begin
			next_count = 3'(count + 3'd1);
			case (state)
				EBPC_E_LOW: begin
					if (next_count == OSC_LOW_CNT) begin
						next_state = EBPC_E_HIGH;
						next_count = 3'd0;
						next_rise  = 1'b1;
						// stretch level looked at only here
						next_limit = stretch_lvl ? OSC_STRETCH_CNT : OSC_HIGH_CNT;
					end
				end
				EBPC_E_HIGH: begin
					if (next_count == limit) begin
						next_state = EBPC_E_LOW;
						next_count = 3'd0;
						next_fall  = 1'b1;
					end
				end
				default: begin
					next_state = EBPC_E_LOW;
					next_count = 3'd0;
				end
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= EBPC_E_LOW;
			count    <= 3'd0;
			limit    <= OSC_HIGH_CNT;
			bus_rise <= 1'b0;
			bus_fall <= 1'b0;
		end else begin
			state    <= next_state;
			count    <= next_count;
			limit    <= next_limit;
			bus_rise <= next_rise;
			bus_fall <= next_fall;
		end
	end

	assign bus_clk = (state == EBPC_E_HIGH);
endmodule : ebpc_eclk_gen

// file: rtl/ebpc_top.sv
/*
 * expanded bus and pin control: bus clock, data strobe, stretch input,
 * mode latching, ports A to E, reset and interrupt pins, apb registers.
 * assumes a cpu core on pclk gives bus requests and instruction starts,
 * and that fault monitors and serial or timer units sit on pclk too.
 */
`timescale 1ns/10ps
module ebpc_top
	import ebpc_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// oscillator and bus clock pins
	input  wire logic        osc_in,
	output logic             osc_out,
	output logic             bus_clk,
	output logic             data_strobe_n,
	input  wire logic        bus_stretch,
	output logic             rw_n,
	// reset pin, open drain
	output logic             reset_pin_out,
	output logic             reset_pin_oe,
	input  wire logic        clock_fail,
	input  wire logic        watchdog_fail,
	// mode pins; mode_sel_a doubles as instr_start_n
	input  wire logic        mode_sel_a,
	input  wire logic        mode_sel_b,
	output logic             instr_start_n,
	output logic             instr_start_oe,
	input  wire logic        instr_start,
	// interrupt request pin
	input  wire logic        irq_n,
	output logic             irq_req,
	// cpu external bus request
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_wdata,
	input  wire logic        cpu_write,
	output logic      [7:0]  cpu_rdata,
	output logic             cpu_cycle_end,
	// port a with timer sharing
	input  wire logic [7:0]  port_a_pins_in,
	output logic      [7:0]  port_a_pins_out,
	output logic      [7:0]  port_a_pins_oe,
	input  wire logic [7:0]  timer_a_out,
	input  wire logic [7:0]  timer_a_en,
	// port b
	output logic      [7:0]  port_b_pins,
	// port c
	input  wire logic [7:0]  port_c_pins_in,
	output logic      [7:0]  port_c_pins_out,
	output logic      [7:0]  port_c_pins_oe,
	// port d with serial sharing
	input  wire logic [5:0]  port_d_pins_in,
	output logic      [5:0]  port_d_pins_out,
	output logic      [5:0]  port_d_pins_oe,
	input  wire logic [5:0]  serial_d_out,
	input  wire logic [5:0]  serial_d_en,
	// port e and converter
	input  wire logic [7:0]  port_e_pins,
	input  wire logic [7:0]  adc_pin_used,
	output logic      [7:0]  port_e_to_adc
);
	import ebpc_pkg::*;

	// ==========================================================
	// helpers
	// pins read back as the latch where driven, the pin elsewhere
	function automatic logic [7:0] pin_mix(input logic [7:0] data, input logic [7:0] dir,
		input logic [7:0] pin);
		pin_mix = (data & dir) | (pin & ~dir);
	endfunction : pin_mix

	function automatic logic [31:0] zext8(input logic [7:0] v);
		zext8 = {24'h000000, v};
	endfunction : zext8

	// ==========================================================
	// synchronisers for every pin input
	logic [1:0]  osc_sync;
	logic [1:0]  stretch_sync;
	logic [1:0]  irq_sync;
	logic [1:0]  mode_sel_a_sync;
	logic [1:0]  mode_sel_b_sync;
	logic [7:0]  pa_s1;
	logic [7:0]  pa_s2;
	logic [7:0]  pc_s1;
	logic [7:0]  pc_s2;
	logic [5:0]  pd_s1;
	logic [5:0]  pd_s2;
	logic [7:0]  pe_s1;
	logic [7:0]  pe_s2;
	logic        osc_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_sync     <= 2'h0;
			stretch_sync <= 2'h0;
			irq_sync     <= 2'h3;
			mode_sel_a_sync    <= 2'h0;
			mode_sel_b_sync    <= 2'h0;
			pa_s1        <= 8'h00;
			pa_s2        <= 8'h00;
			pc_s1        <= 8'h00;
			pc_s2        <= 8'h00;
			pd_s1        <= 6'h00;
			pd_s2        <= 6'h00;
			pe_s1        <= 8'h00;
			pe_s2        <= 8'h00;
			osc_prev     <= 1'b0;
		end else begin
			osc_sync     <= {osc_sync[0], osc_in};
			stretch_sync <= {stretch_sync[0], bus_stretch};
			irq_sync     <= {irq_sync[0], irq_n};
			mode_sel_a_sync    <= {mode_sel_a_sync[0], mode_sel_a};
			mode_sel_b_sync    <= {mode_sel_b_sync[0], mode_sel_b};
			pa_s1        <= port_a_pins_in;
			pa_s2        <= pa_s1;
			pc_s1        <= port_c_pins_in;
			pc_s2        <= pc_s1;
			pd_s1        <= port_d_pins_in;
			pd_s2        <= pd_s1;
			pe_s1        <= port_e_pins;
			pe_s2        <= pe_s1;
			osc_prev     <= osc_sync[1];
		end
	end

	// ==========================================================
	// bus clock
	logic osc_rise;
	logic bus_rise;
	logic bus_fall;

	assign osc_rise = osc_sync[1] & ~osc_prev;

	ebpc_eclk_gen u_eclk (
		.pclk        (pclk),
		.presetn     (presetn),
		.osc_rise    (osc_rise),
		.stretch_lvl (stretch_sync[1]),
		.bus_clk     (bus_clk),
		.bus_rise    (bus_rise),
		.bus_fall    (bus_fall)
	);

	assign data_strobe_n = ~bus_clk;

	// ==========================================================
	// mode latch: pins must settle through the synchroniser first
	logic [1:0] mode;
	logic [1:0] next_mode;
	logic [1:0] cap_cnt;
	logic [1:0] next_cap_cnt;
	logic       mode_ok;
	logic       next_mode_ok;
	logic       expanded;

	always_comb begin
		next_mode    = mode;
		next_cap_cnt = cap_cnt;
		next_mode_ok = mode_ok;
		if (!mode_ok) begin
			next_cap_cnt = 2'(cap_cnt + 2'd1);
			if (cap_cnt == MODE_CAPTURE_CNT) begin
				next_mode    = {mode_sel_b_sync[1], mode_sel_a_sync[1]};
				next_mode_ok = 1'b1;
			end
		end
	end

	// test mode also runs the external bus
	assign expanded = mode_ok & mode[0];

	// ==========================================================
	// external bus: address presented from the fall, data in the high phase
	logic [15:0] bus_addr;
	logic [15:0] next_bus_addr;
	logic [7:0]  bus_wdata;
	logic [7:0]  next_bus_wdata;
	logic        bus_write;
	logic        next_bus_write;
	logic [7:0]  next_cpu_rdata;

	always_comb begin
		next_bus_addr  = bus_addr;
		next_bus_wdata = bus_wdata;
		next_bus_write = bus_write;
		next_cpu_rdata = cpu_rdata;
		if (bus_fall) begin
			next_cpu_rdata = pc_s2;
			next_bus_addr  = cpu_addr;
			next_bus_wdata = cpu_wdata;
			next_bus_write = cpu_write & expanded;
		end
	end

	assign cpu_cycle_end = bus_fall;
	assign rw_n          = ~(expanded & bus_write);

	// ==========================================================
	// apb registers
	logic [7:0] pa_data;
	logic [7:0] pa_dir;
	logic [7:0] pb_data;
	logic [7:0] pc_data;
	logic [7:0] pc_dir;
	logic [5:0] pd_data;
	logic [5:0] pd_dir;
	logic       irq_en;
	logic [7:0] next_pa_data;
	logic [7:0] next_pa_dir;
	logic [7:0] next_pb_data;
	logic [7:0] next_pc_data;
	logic [7:0] next_pc_dir;
	logic [5:0] next_pd_data;
	logic [5:0] next_pd_dir;
	logic       next_irq_en;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic [7:0]  idx;
	logic        hit;
	logic [7:0]  pe_read;
	logic [7:0]  status;

	assign idx     = paddr[IDX_LSB +: 8];
	// pins the converter owns read as zero
	assign pe_read = pe_s2 & ~adc_pin_used;
	assign status  = {3'h0, clock_fail | watchdog_fail, irq_req, mode_ok, mode};

	always_comb begin
		hit = 1'b1;
		case (idx)
			IDX_PORT_A_DATA:  next_prdata = zext8(pin_mix(pa_data, pa_dir, pa_s2));
			IDX_PORT_A_DIR:   next_prdata = zext8(pa_dir);
			IDX_PORT_B_DATA:  next_prdata = zext8(pb_data);
			IDX_PORT_C_DATA:  next_prdata = zext8(pin_mix(pc_data, pc_dir, pc_s2));
			IDX_PORT_C_DIR:   next_prdata = zext8(pc_dir);
			IDX_PORT_D_DATA:  next_prdata = zext8(pin_mix({2'h0, pd_data}, {2'h0, pd_dir}, {2'h0, pd_s2}));
			IDX_PORT_D_DIR:   next_prdata = zext8({2'h0, pd_dir});
			IDX_PORT_E_INPUT: next_prdata = zext8(pe_read);
			IDX_SYS_CTRL:     next_prdata = zext8({7'h00, irq_en});
			IDX_SYS_STATUS:   next_prdata = zext8(status);
			default: begin
				next_prdata = 32'h00000000;
				hit         = 1'b0;
			end
		endcase
		if (|paddr[1:0] || |paddr[31:IDX_LSB + 8]) begin
			hit         = 1'b0;
			next_prdata = 32'h00000000;
		end
		next_pslverr = ~hit;
		// read data is set up during the setup phase, answered without waits
		if (!(psel && !penable)) begin
			next_prdata  = prdata;
			next_pslverr = pslverr;
		end
		next_pa_data = pa_data;
		next_pa_dir  = pa_dir;
		next_pb_data = pb_data;
		next_pc_data = pc_data;
		next_pc_dir  = pc_dir;
		next_pd_data = pd_data;
		next_pd_dir  = pd_dir;
		next_irq_en  = irq_en;
		if (psel && penable && pwrite && hit) begin
			case (idx)
				IDX_PORT_A_DATA: next_pa_data = pwdata[7:0];
				IDX_PORT_A_DIR:  next_pa_dir  = pwdata[7:0];
				IDX_PORT_B_DATA: next_pb_data = pwdata[7:0];
				IDX_PORT_C_DATA: next_pc_data = pwdata[7:0];
				IDX_PORT_C_DIR:  next_pc_dir  = pwdata[7:0];
				IDX_PORT_D_DATA: next_pd_data = pwdata[5:0];
				IDX_PORT_D_DIR:  next_pd_dir  = pwdata[5:0];
				IDX_SYS_CTRL:    next_irq_en  = pwdata[CTRL_IRQ_EN_BIT];
				default: begin
					next_irq_en = irq_en;
				end
			endcase
		end
	end

	assign pready = 1'b1;

	// ==========================================================
	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode      <= RST_MODE;
			cap_cnt   <= 2'd0;
			mode_ok   <= 1'b0;
			bus_addr  <= 16'h0000;
			bus_wdata <= 8'h00;
			bus_write <= 1'b0;
			cpu_rdata <= 8'h00;
			pa_data   <= RST_PORT_DATA;
			pa_dir    <= RST_PORT_DIR;
			pb_data   <= RST_PORT_DATA;
			pc_data   <= RST_PORT_DATA;
			pc_dir    <= RST_PORT_DIR;
			pd_data   <= RST_PORT_D6;
			pd_dir    <= RST_PORT_D6;
			irq_en    <= RST_IRQ_EN;
			prdata    <= 32'h00000000;
			pslverr   <= 1'b0;
			osc_out   <= 1'b1;
		end else begin
			mode      <= next_mode;
			cap_cnt   <= next_cap_cnt;
			mode_ok   <= next_mode_ok;
			bus_addr  <= next_bus_addr;
			bus_wdata <= next_bus_wdata;
			bus_write <= next_bus_write;
			cpu_rdata <= next_cpu_rdata;
			pa_data   <= next_pa_data;
			pa_dir    <= next_pa_dir;
			pb_data   <= next_pb_data;
			pc_data   <= next_pc_data;
			pc_dir    <= next_pc_dir;
			pd_data   <= next_pd_data;
			pd_dir    <= next_pd_dir;
			irq_en    <= next_irq_en;
			prdata    <= next_prdata;
			pslverr   <= next_pslverr;
			// inverting buffer of the oscillator, three pclk late
			osc_out   <= ~osc_sync[1];
		end
	end

	// ==========================================================
	// pins
	assign port_a_pins_out = (timer_a_en & timer_a_out) | (~timer_a_en & pa_data);
	assign port_a_pins_oe  = pa_dir | timer_a_en;
	assign port_b_pins     = expanded ? bus_addr[15:8] : pb_data;
	// data bus driven only on writes while the bus clock is high
	assign port_c_pins_out = expanded ? bus_wdata : pc_data;
	assign port_c_pins_oe  = expanded ? {8{bus_write & bus_clk}} : pc_dir;
	assign port_d_pins_out = (serial_d_en & serial_d_out) | (~serial_d_en & pd_data);
	assign port_d_pins_oe  = pd_dir | serial_d_en;
	assign port_e_to_adc   = pe_s2;

	assign reset_pin_out  = 1'b0;
	assign reset_pin_oe   = clock_fail | watchdog_fail;
	// pin is released to the mode strap until the mode is latched
	assign instr_start_n  = 1'b0;
	assign instr_start_oe = mode_ok & instr_start;
	assign irq_req        = irq_en & ~irq_sync[1];
endmodule : ebpc_top

// file: dv/ebpc_checker_assertions.sv
/*
 * checker for ebpc_top: bus clock phases, strobe, data drive and pin rules.
 * assumes osc_in far slower than pclk and bus_stretch changing only in the low phase.
 */
`timescale 1ns/10ps
module ebpc_checker (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// bus clock pins
	input wire logic       osc_in,
	input wire logic       bus_clk,
	input wire logic       data_strobe_n,
	input wire logic       bus_stretch,
	input wire logic       rw_n,
	// port enables
	input wire logic [7:0] port_a_pins_oe,
	input wire logic [7:0] port_c_pins_oe,
	input wire logic [5:0] port_d_pins_oe,
	// reset, mode and interrupt pins
	input wire logic       reset_pin_out,
	input wire logic       reset_pin_oe,
	input wire logic       clock_fail,
	input wire logic       watchdog_fail,
	input wire logic       instr_start_n,
	input wire logic       instr_start_oe,
	input wire logic       instr_start,
	input wire logic       irq_n,
	input wire logic       irq_req
);
	// ==========================================================
	// osc rises counted per bus clock phase, pin edges so sync lag cancels
	logic       osc_q, bq, st, next_st;
	logic [2:0] hi_cnt, lo_cnt, next_hi, next_lo;
	always_comb begin
		next_hi = bus_clk ? hi_cnt + {2'h0, osc_in & ~osc_q} : 3'h0;
		next_lo = bus_clk ? 3'h0 : lo_cnt + {2'h0, osc_in & ~osc_q};
		next_st = (bus_clk & ~bq) ? bus_stretch : st;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q  <= 1'b0;
			bq     <= 1'b0;
			st     <= 1'b0;
			hi_cnt <= 3'h0;
			lo_cnt <= 3'h0;
		end else begin
			osc_q  <= osc_in;
			bq     <= bus_clk;
			st     <= next_st;
			hi_cnt <= next_hi;
			lo_cnt <= next_lo;
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_strobe_inverse: assert property (data_strobe_n == !bus_clk)
		else $error("strobe not inverse of bus clock");
	a_low_phase: assert property ($rose(bus_clk) |-> lo_cnt == 3'h2)
		else $error("low phase not two osc rises");
	a_high_phase: assert property ($fell(bus_clk) |-> hi_cnt == (st ? 3'h4 : 3'h2))
		else $error("high phase length wrong");
	a_write_drive: assert property (!rw_n && bus_clk && $past(bus_clk) |-> port_c_pins_oe == 8'hFF)
		else $error("write data not driven in high phase");
	a_addr_quiet: assert property (!rw_n && !bus_clk && !$past(bus_clk) |-> port_c_pins_oe == 8'h00)
		else $error("data bus driven in low phase");
	a_fault_pull: assert property ((clock_fail || watchdog_fail) |-> ##[0:3] (reset_pin_oe && !reset_pin_out))
		else $error("reset pin not pulled on fault");
	a_instr_pulse: assert property (instr_start_oe |-> !instr_start_n && (instr_start || $past(instr_start)))
		else $error("instruction start pulse without cause");
	a_irq_cause: assert property (irq_req |-> !$past(irq_n, 2))
		else $error("interrupt request without low pin");
	a_ports_reset: assert property ($rose(presetn) |-> (port_a_pins_oe | port_c_pins_oe) == 8'h00 && port_d_pins_oe == 6'h00)
		else $error("port enables not clear after reset");
	c_stretch: cover property ($fell(bus_clk) && st);
	c_write: cover property (!rw_n && bus_clk);
	c_fault: cover property (reset_pin_oe);
endmodule : ebpc_checker

bind ebpc_top ebpc_checker u_chk (.pclk(pclk), .presetn(presetn), .osc_in(osc_in), .bus_clk(bus_clk),
	.data_strobe_n(data_strobe_n), .bus_stretch(bus_stretch), .rw_n(rw_n), .port_a_pins_oe(port_a_pins_oe),
	.port_c_pins_oe(port_c_pins_oe), .port_d_pins_oe(port_d_pins_oe), .reset_pin_out(reset_pin_out),
	.reset_pin_oe(reset_pin_oe), .clock_fail(clock_fail), .watchdog_fail(watchdog_fail),
	.instr_start_n(instr_start_n), .instr_start_oe(instr_start_oe), .instr_start(instr_start),
	.irq_n(irq_n), .irq_req(irq_req));

// file: dv/ebpc_ext_mem.sv
/*
 * external memory on the expanded bus, indexed by the upper address byte.
 * assumes bus_clk, rw_n and port pins of ebpc_top; slow asks for stretched cycles.
 */
`timescale 1ns/10ps
module ebpc_ext_mem (
	// bus side
	input wire logic       pclk,
	input wire logic       bus_clk,
	input wire logic       rw_n,
	input wire logic       slow,
	input wire logic [7:0] addr_hi,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_oe,
	// answers
	output logic     [7:0] data_out,
	output logic           bus_stretch
);
	logic [7:0] mem [256];
	logic       bq = 1'b0;
	initial data_out = 8'h00;
	initial bus_stretch = 1'b0;
	always @(posedge pclk) begin
		bq <= bus_clk;
		// set after a fall, far from the sampling rise
		if (bq && !bus_clk) bus_stretch <= slow;
		if (bus_clk && !rw_n && data_oe == 8'hFF) mem[addr_hi] <= data_in;
		// released bus toggles so a stale value never looks valid
		data_out <= (bus_clk && rw_n) ? mem[addr_hi] : ~data_out;
	end
endmodule : ebpc_ext_mem

// file: dv/ebpc_top_bench.sv
/*
 * bench for ebpc_top: apb register tests, strap modes, expanded bus cycles.
 * assumes rtl/ebpc_pkg.sv and the checker are compiled before it.
 */
`timescale 1ns/10ps
module ebpc_top_bench;
	import ebpc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
	logic        pready, pslverr, osc_in = 1'b0, osc_out, bus_clk, data_strobe_n, bus_stretch, rw_n;
	logic        reset_pin_out, reset_pin_oe, clock_fail = 1'b0, watchdog_fail = 1'b0;
	logic        mode_sel_a = 1'b0, mode_sel_b = 1'b0, instr_start_n, instr_start_oe, instr_start = 1'b0;
	logic        irq_n = 1'b1, irq_req, cpu_write = 1'b0, cpu_cycle_end, slow = 1'b0, osc_run = 1'b0;
	logic [15:0] cpu_addr = 16'h0;
	logic [7:0]  cpu_wdata = 8'h0, cpu_rdata, ext_a = 8'h0, ext_c, ext_e = 8'h0, adc_used = 8'h0;
	logic [7:0]  pa_in, pa_out, pa_oe, pb, pc_in, pc_out, pc_oe, pe_adc;
	logic [5:0]  pd_in, pd_out, pd_oe;
	logic [1:0]  ocnt = 2'h0;
	int          fail_count = 0, total_checks = 0;
	// ==========================================================
	// pins resolved from the dut's output enables, with outside drivers on ports a and c
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
	assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
	assign pd_in = pd_oe & pd_out;
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		ocnt <= osc_run ? ocnt + 2'h1 : 2'h0;
		osc_in <= osc_run & (osc_in ^ (ocnt == 2'h3));
	end
	ebpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_in(osc_in), .osc_out(osc_out), .bus_clk(bus_clk), .data_strobe_n(data_strobe_n),
		.bus_stretch(bus_stretch), .rw_n(rw_n), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.clock_fail(clock_fail), .watchdog_fail(watchdog_fail), .mode_sel_a(mode_sel_a),
		.mode_sel_b(mode_sel_b), .instr_start_n(instr_start_n), .instr_start_oe(instr_start_oe),
		.instr_start(instr_start), .irq_n(irq_n), .irq_req(irq_req), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_write(cpu_write), .cpu_rdata(cpu_rdata), .cpu_cycle_end(cpu_cycle_end),
		.port_a_pins_in(pa_in), .port_a_pins_out(pa_out), .port_a_pins_oe(pa_oe), .timer_a_out(ext_e),
		.timer_a_en(adc_used), .port_b_pins(pb), .port_c_pins_in(pc_in), .port_c_pins_out(pc_out),
		.port_c_pins_oe(pc_oe), .port_d_pins_in(pd_in), .port_d_pins_out(pd_out), .port_d_pins_oe(pd_oe),
		.serial_d_out(ext_e[5:0]), .serial_d_en(adc_used[5:0]), .port_e_pins(ext_e), .adc_pin_used(adc_used),
		.port_e_to_adc(pe_adc));
	ebpc_ext_mem u_mem (.pclk(pclk), .bus_clk(bus_clk), .rw_n(rw_n), .slow(slow), .addr_hi(pb),
		.data_in(pc_out), .data_oe(pc_oe), .data_out(ext_c), .bus_stretch(bus_stretch));
	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {22'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask : wr
	task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp, input logic eexp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 32'h0, r, e);
		chk(what, exp, r);
		chk("slave error", {31'h0, eexp}, {31'h0, e});
	endtask : rdc
	task automatic rst(input logic [1:0] m);
		@(posedge pclk);
		presetn <= 1'b0;
		osc_run <= 1'b0;
		{mode_sel_b, mode_sel_a} <= m;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		osc_run <= 1'b1;
	endtask : rst
	task automatic wait_end;
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (cpu_cycle_end !== 1'b1 && n < 200);
		if (n >= 200) fail_count++;
	endtask : wait_end
	// one expanded bus cycle; the partner stretches it when sl is set
	task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic sl);
		@(posedge pclk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_write <= w;
		slow <= sl;
		wait_end();
		repeat (2) @(negedge pclk);
		chk("address high", {24'h0, a[15:8]}, {24'h0, pb});
		chk("direction", {31'h0, !w}, {31'h0, rw_n});
		wait_end();
		repeat (3) @(negedge pclk);
		if (!w) chk("bus read", {24'h0, d}, {24'h0, cpu_rdata});
	endtask : cyc
	task automatic results;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	// ==========================================================
	// tests
	initial begin
		for (int m = 0; m < 4; m++) begin
			rst(2'(m));
			rdc("status", IDX_SYS_STATUS, 32'(4 | m), 1'b0);
			chk("port a enable", 32'h0, {24'h0, pa_oe});
			chk("osc out", 32'h1, {31'h0, osc_out});
		end
		cyc(16'h5A00, 8'h3C, 1'b1, 1'b0);
		cyc(16'hA500, 8'hC3, 1'b1, 1'b1);
		cyc(16'h5A00, 8'h3C, 1'b0, 1'b1);
		cyc(16'hA500, 8'hC3, 1'b0, 1'b0);
		rst(2'b10);
		ext_a <= 8'h3C;
		ext_e <= 8'h5A;
		adc_used <= 8'h0F;
		wr(IDX_PORT_A_DIR, 32'h0F);
		wr(IDX_PORT_A_DATA, 32'hA5);
		rdc("port a", IDX_PORT_A_DATA, 32'h35, 1'b0);
		chk("port a pins", 32'h0FAA, {16'h0, pa_oe, pa_out});
		wr(IDX_PORT_B_DATA, 32'hC3);
		wr(IDX_PORT_C_DIR, 32'hFF);
		chk("port b", 32'hC3, {24'h0, pb});
		wr(IDX_PORT_C_DATA, 32'h96);
		wr(IDX_PORT_D_DIR, 32'hFF);
		chk("port c", 32'hFF96, {16'h0, pc_oe, pc_out});
		wr(IDX_PORT_D_DATA, 32'hFF);
		rdc("port d", IDX_PORT_D_DATA, 32'h3F, 1'b0);
		chk("port d pins", 32'h3F3A, {18'h0, pd_oe, 2'h0, pd_out});
		rdc("port e", IDX_PORT_E_INPUT, 32'h50, 1'b0);
		chk("converter pins", 32'h5A, {24'h0, pe_adc});
		rdc("unmapped", 8'h20, 32'h0, 1'b1);
		wr(IDX_SYS_CTRL, 32'h1);
		irq_n <= 1'b0;
		repeat (5) @(negedge pclk);
		chk("irq on", 32'h1, {31'h0, irq_req});
		wr(IDX_SYS_CTRL, 32'h0);
		@(negedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq_req});
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk);
			{clock_fail, watchdog_fail} <= i ? 2'b01 : 2'b10;
			repeat (4) @(negedge pclk);
			chk("reset pull", 32'h2, {30'h0, reset_pin_oe, reset_pin_out});
			@(posedge pclk);
			{clock_fail, watchdog_fail} <= 2'b00;
			repeat (4) @(negedge pclk);
			chk("reset free", 32'h0, {31'h0, reset_pin_oe});
		end
		@(posedge pclk);
		instr_start <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("instr start", 32'h2, {30'h0, instr_start_oe, instr_start_n});
		results();
	end
	initial begin
		#80000;
		fail_count++;
		results();
	end
endmodule : ebpc_top_bench
